// >>> design/ttc_pkg.sv
package ttc_pkg;
    // register byte offsets
    localparam logic [3:0] TTC_CTRL_OFS = 4'h0;
    localparam logic [3:0] TTC_STAT_OFS = 4'h4;
    localparam logic [3:0] TTC_IRQ_STAT_OFS = 4'h8;
    localparam logic [3:0] TTC_IRQ_CLR_OFS = 4'hC;
    localparam logic [4:0] TTC_IRQ_EN_OFS = 5'h10;
    localparam logic [4:0] TTC_PSTATE_OFS = 5'h14;
    // control field positions
    localparam int TTC_AUTO_EN_BIT = 0;
    localparam int TTC_AUTO_SEL_BIT = 5;
    localparam int TTC_OD_EN_BIT = 4;
    localparam int TTC_OD_DUTY_LO = 1;
    localparam int TTC_OD_DUTY_HI = 3;
    localparam logic [31:0] TTC_CTRL_RST = 32'h0000_0000;
    localparam logic [3:0] TTC_PSTATE_RST = 4'hF;
    localparam logic [3:0] TTC_PSTATE_LOW = 4'h0;
    // modulation window: 8 steps of 12.5 percent
    localparam logic [2:0] TTC_AUTO_DUTY = 3'h3;
    localparam int TTC_STEP_CYC = 16;
    localparam logic [3:0] TTC_STEP_MAX = 4'(TTC_STEP_CYC - 1);
    localparam int TTC_HYST_CYC = 64;
    localparam logic [5:0] TTC_HYST_MAX = 6'(TTC_HYST_CYC - 1);
    // irq status bits
    localparam int TTC_EV_HOT_RISE = 0;
    localparam int TTC_EV_HOT_FALL = 1;
    localparam int TTC_EV_ACT = 2;
    typedef enum logic {TTC_VAR_CLKMOD, TTC_VAR_PSTATE} ttc_var_t;
endpackage

// >>> design/ttc_throttle.sv
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// [R1] trip threshold fixed, not software visible
// [R2] automatic activation only at maximum temperature
// [R3] bus snooping continues during throttling
// [R4] interrupts latched, serviced while clocks run
// [R5] throttle by clock gating or lower operating point
// [R6] automatic and on-demand; automatic wins
// [R7] automatic variant chosen by config register
// [R8] firmware must enable automatic mode
// [R9] automatic clock modulation fixed 50 percent
// [R10] pstate variant returns to last requested point
// [R11] ctrl bit4 on-demand, bits3:1 duty
// [R12] active-low hot output while above trip
// [R13] trip input synchronised before use
module ttc_throttle (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic temp_trip_in,
    input wire logic snoop_req,
    output logic snoop_ack,
    input wire logic irq_in,
    output logic irq_service,
    output logic core_clk_en,
    output logic [3:0] pstate_out,
    output logic thermal_throttle_unit_active,
    output logic overtemp_out_n,
    output logic irq
);
    import ttc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [2:0] trip_sync_r;
    logic hot_r;
    logic [5:0] hyst_r;
    logic [31:0] ctrl_r;
    logic [3:0] pstate_req_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_en_r;
    logic [3:0] step_r;
    logic [2:0] phase_r;
    logic irq_pend_r;
    logic act_d_r;
    logic ack_r;
    logic [31:0] rdata_r;

    wire acc = avs_read | avs_write;
    wire wr_go = avs_write & ack_r;
    wire rd_go = avs_read & ~ack_r;
    wire sel_ctrl = (avs_address == 5'(TTC_CTRL_OFS));
    wire sel_stat = (avs_address == 5'(TTC_STAT_OFS));
    wire sel_istat = (avs_address == 5'(TTC_IRQ_STAT_OFS));
    wire sel_iclr = (avs_address == 5'(TTC_IRQ_CLR_OFS));
    wire sel_ien = (avs_address == TTC_IRQ_EN_OFS);
    wire sel_ps = (avs_address == TTC_PSTATE_OFS);
    wire full_lo = avs_byteenable[0];

    ////////////////////////////////////////////////////////////////////////
    // three stages, change accepted when stages 2 and 3 agree [R13]
    wire trip_agree = (trip_sync_r[1] == trip_sync_r[2]);
    always_ff @(posedge clk)
    begin
        if (rst)
            trip_sync_r <= 3'h0;
        else
            trip_sync_r <= {trip_sync_r[1:0], temp_trip_in};
    end

    // trip level is the sensor's fixed threshold; no register holds it [R1]
    // small hysteresis: release only after the trip stays low a while
    wire hyst_done = (hyst_r == TTC_HYST_MAX);
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hot_r <= 1'b0;
            hyst_r <= 6'h00;
        end
        else if (trip_agree && trip_sync_r[2])
        begin
            hot_r <= 1'b1;
            hyst_r <= 6'h00;
        end
        else if (trip_agree && hot_r)
        begin
            hyst_r <= hyst_done ? hyst_r : hyst_r + 6'h01;
            hot_r <= ~hyst_done;
        end
    end

    assign overtemp_out_n = ~hot_r; // [R12]

    ////////////////////////////////////////////////////////////////////////
    wire auto_en = ctrl_r[TTC_AUTO_EN_BIT]; // firmware duty to set [R8]
    wire auto_var = ctrl_r[TTC_AUTO_SEL_BIT]; // [R7]
    wire od_en = ctrl_r[TTC_OD_EN_BIT];
    wire [2:0] od_duty = ctrl_r[TTC_OD_DUTY_HI:TTC_OD_DUTY_LO];
    wire auto_act = auto_en & hot_r; // [R2]
    wire auto_mod = auto_act & (ttc_var_t'(auto_var) == TTC_VAR_CLKMOD);
    wire auto_ps = auto_act & (ttc_var_t'(auto_var) == TTC_VAR_PSTATE);
    // od activates regardless of temperature [R11]
    wire od_act = od_en & ~auto_act; // automatic wins [R6]
    wire mod_act = auto_mod | od_act; // [R5]
    wire [2:0] duty = auto_mod ? TTC_AUTO_DUTY : od_duty; // [R9] [R11]
    wire tcc_act = auto_act | od_act;

    ////////////////////////////////////////////////////////////////////////
    // modulation: clocks run while phase <= duty and phase != 7 (duty+1 of 8 steps, at most 7)
    wire step_end = (step_r == TTC_STEP_MAX);
    // counters restart whenever throttling drops, so each episode opens on
    always_ff @(posedge clk)
    begin
        if (rst || !mod_act)
            step_r <= 4'h0;
        else
            step_r <= step_r + 4'h1;
    end

    // phase keeps running across duty changes; no glitch on rewrite
    always_ff @(posedge clk)
    begin
        if (rst || !mod_act)
            phase_r <= 3'h0;
        else if (step_end)
            phase_r <= phase_r + 3'h1;
    end

    // bits 3:1 = 0 means 12.5 percent on, 7 means 87.5 percent
    wire clk_on = ~mod_act | (phase_r <= duty) && (phase_r != 3'h7); // [R5] [R9]

    always_ff @(posedge clk)
    begin
        if (rst)
            core_clk_en <= 1'b1;
        else
            core_clk_en <= clk_on;
    end

    // lower point while hot, else the last requested one [R10]
    always_ff @(posedge clk)
    begin
        if (rst)
            pstate_out <= TTC_PSTATE_RST;
        else if (auto_ps && pstate_req_r > TTC_PSTATE_LOW)
            pstate_out <= TTC_PSTATE_LOW; // [R5]
        else
            pstate_out <= pstate_req_r; // [R10]
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            thermal_throttle_unit_active <= 1'b0;
        else
            thermal_throttle_unit_active <= tcc_act;
    end

    ////////////////////////////////////////////////////////////////////////
    // snoop path is independent of throttle state [R3]
    always_ff @(posedge clk)
    begin
        if (rst)
            snoop_ack <= 1'b0;
        else
            snoop_ack <= snoop_req; // [R3]
    end

    // latch requests; deliver only in clock-on windows [R4]
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_pend_r <= 1'b0;
            irq_service <= 1'b0;
        end
        else
        begin
            irq_service <= irq_pend_r & clk_on; // [R4]
            if (irq_in)
                irq_pend_r <= 1'b1;
            else if (irq_pend_r && clk_on)
                irq_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events; set wins over a simultaneous clear
    wire hot_d = trip_agree & trip_sync_r[2] & ~hot_r;
    wire cool_d = hot_r & trip_agree & ~trip_sync_r[2] & hyst_done;
    wire act_rise = tcc_act & ~act_d_r;
    wire [2:0] ev_set = {act_rise, cool_d, hot_d};
    wire [2:0] ev_clr = (wr_go && sel_iclr && full_lo) ? avs_writedata[2:0] : 3'h0;
    always_ff @(posedge clk)
    begin
        if (rst)
            act_d_r <= 1'b0;
        else
            act_d_r <= tcc_act;
    end

    // one sticky bit per event
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_ev
            always_ff @(posedge clk)
            begin
                if (rst)
                    irq_stat_r[gi] <= 1'b0;
                else if (ev_set[gi])
                    irq_stat_r[gi] <= 1'b1; // set wins, no lost event
                else if (ev_clr[gi])
                    irq_stat_r[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_r & irq_en_r);
    end

    ////////////////////////////////////////////////////////////////////////
    // one wait cycle per access keeps the slave simple
    assign avs_waitrequest = acc & ~ack_r;
    always_ff @(posedge clk)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= acc & ~ack_r;
    end

    // writes land only at the edge that ends the cycle after the wait cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl_r <= TTC_CTRL_RST;
        else if (wr_go && full_lo && sel_ctrl)
            ctrl_r <= {26'h0, avs_writedata[5:0]}; // [R7] [R11]
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            irq_en_r <= 3'h0;
        else if (wr_go && full_lo && sel_ien)
            irq_en_r <= avs_writedata[2:0];
    end

    // request is kept even while hot, so cooling returns to it [R10]
    always_ff @(posedge clk)
    begin
        if (rst)
            pstate_req_r <= TTC_PSTATE_RST;
        else if (wr_go && full_lo && sel_ps)
            pstate_req_r <= avs_writedata[3:0];
    end

    wire [31:0] stat_word = {28'h0, tcc_act, ~core_clk_en, auto_act, hot_r};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_r :
                         sel_stat ? stat_word :
                         sel_istat ? {29'h0, irq_stat_r} :
                         sel_ien ? {29'h0, irq_en_r} :
                         sel_ps ? {28'h0, pstate_req_r} : 32'h0;
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_r <= 32'h0;
        else if (rd_go)
            rdata_r <= rd_mux;
    end
    assign avs_readdata = rdata_r;
endmodule

// >>> tb/ttc_sensor_model.sv
`timescale 1ns/1ns
// far side: on-die trip comparator, level out
module ttc_sensor_model (
    input wire logic clk,
    input wire logic hot_cmd,
    output logic temp_trip_in = 1'b0
);
    // no glitches modelled; the sync stage is the design's job
    always @(posedge clk)
    begin
        temp_trip_in <= hot_cmd;
    end
endmodule

// >>> tb/ttc_throttle_sva.sv
`timescale 1ns/1ns
module ttc_throttle_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic temp_trip_in,
    input wire logic snoop_req,
    input wire logic snoop_ack,
    input wire logic irq_service,
    input wire logic core_clk_en,
    input wire logic thermal_throttle_unit_active,
    input wire logic overtemp_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // run length of gated clock
    logic [7:0] off_r;
    always_ff @(posedge clk)
    begin
        off_r <= (rst || core_clk_en) ? 8'h00 : off_r + 8'h01;
    end
    sequence acc_s; avs_waitrequest ##1 !avs_waitrequest; endsequence
    sequence hot_s; temp_trip_in [*6]; endsequence
    snoop_echo_a: assert property (snoop_ack == $past(snoop_req))
        else $error("snoop ack lost");
    read_wait_a: assert property ($rose(avs_read) |-> acc_s) else $error("read wait");
    write_wait_a: assert property ($rose(avs_write) |-> acc_s) else $error("write wait");
    hot_rise_a: assert property (hot_s |-> !overtemp_out_n) else $error("hot late");
    hot_cause_a: assert property ($fell(overtemp_out_n) |-> $past(temp_trip_in, 3))
        else $error("hot no cause");
    cool_cause_a: assert property ($rose(overtemp_out_n) |-> !$past(temp_trip_in, 8))
        else $error("cool early");
    gate_cause_a: assert property (!core_clk_en |-> thermal_throttle_unit_active
        || $past(thermal_throttle_unit_active)) else $error("gated idle");
    irq_run_a: assert property (irq_service |-> core_clk_en || $past(core_clk_en))
        else $error("irq while gated");
    off_len_a: assert property (off_r <= 8'h70) else $error("gated too long");
endmodule
bind ttc_throttle ttc_throttle_sva chk_i (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
    .temp_trip_in, .snoop_req, .snoop_ack, .irq_service, .core_clk_en, .thermal_throttle_unit_active,
    .overtemp_out_n);

// >>> tb/ttc_throttle_bench.sv
`timescale 1ns/1ns
module ttc_throttle_bench;
    import ttc_pkg::*;
    logic clk = 0, rst = 1, rd_en = 0, wr_en = 0, hot = 0, snp = 0, iq = 0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [31:0] rdq;
    logic wt, sack, isv, cen, act, ovn, irq, trip;
    logic [3:0] ps;
    int num_errors = 0, checks = 0;
    always #4 clk = ~clk;
    ttc_sensor_model sen (.clk(clk), .hot_cmd(hot), .temp_trip_in(trip));
    ttc_throttle dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdq), .avs_waitrequest(wt),
        .temp_trip_in(trip), .snoop_req(snp), .snoop_ack(sack), .irq_in(iq), .irq_service(isv),
        .core_clk_en(cen), .pstate_out(ps), .thermal_throttle_unit_active(act), .overtemp_out_n(ovn),
        .irq(irq));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // one idle cycle after each access keeps strobes single-driven
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr_en <= w;
        rd_en <= !w;
        @(posedge clk);
        while (wt !== 1'b0 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 50) num_errors++;
        rdat = rdq;
        wr_en <= 0;
        rd_en <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic wait_ovn(input logic v);
        int n = 0;
        while (ovn !== v && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        repeat (8) @(posedge clk);
        chk(ovn, v);
    endtask
    // a 128 cycle window is one whole modulation period
    task automatic on_cnt(input int e);
        int n = 0;
        repeat (128) @(posedge clk);
        repeat (128)
        begin
            @(negedge clk);
            if (cen === 1'b1) n++;
        end
        chk(n, e);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({cen, ps, ovn, act, irq}, 8'hFC);
        rd(TTC_CTRL_OFS, TTC_CTRL_RST);
        rd(TTC_PSTATE_OFS, 32'(TTC_PSTATE_RST));
        rd(5'h18, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_auto;
        int n = 0;
        bus(1, TTC_IRQ_EN_OFS, 32'h7);
        bus(1, TTC_CTRL_OFS, 32'h1);
        chk(act, 0);
        hot <= 1;
        wait_ovn(0);
        chk({act, irq}, 2'h3);
        snp <= 1;
        iq <= 1;
        @(posedge clk);
        iq <= 0;
        while (isv !== 1'b1 && n < 140)
        begin
            @(negedge clk);
            n++;
        end
        chk(isv, 1);
        chk(sack, 1);
        snp <= 0;
        on_cnt(64);
        rd(TTC_IRQ_STAT_OFS, 32'h5);
        bus(1, TTC_IRQ_CLR_OFS, 32'h7);
        hot <= 0;
        wait_ovn(1);
        chk({act, cen}, 2'h1);
        rd(TTC_IRQ_STAT_OFS, 32'h2);
        bus(1, TTC_IRQ_CLR_OFS, 32'h7);
        @(posedge clk);
        chk(irq, 0);
        $display("auto clock test done");
    endtask
    task automatic t_pstate;
        bus(1, TTC_PSTATE_OFS, 32'h5);
        bus(1, TTC_CTRL_OFS, 32'h21);
        chk(ps, 4'h5);
        hot <= 1;
        wait_ovn(0);
        chk(ps, TTC_PSTATE_LOW);
        hot <= 0;
        wait_ovn(1);
        chk(ps, 4'h5);
        $display("pstate test done");
    endtask
    task automatic t_demand;
        int dl[3] = '{0, 2, 7};
        foreach (dl[i])
        begin
            bus(1, TTC_CTRL_OFS, 32'h10 | 32'(dl[i] << 1));
            @(posedge clk);
            chk(act, 1);
            on_cnt(dl[i] == 7 ? 112 : (dl[i] + 1) * 16);
        end
        bus(1, TTC_CTRL_OFS, 32'h11);
        hot <= 1;
        wait_ovn(0);
        on_cnt(64);
        hot <= 0;
        wait_ovn(1);
        $display("on demand test done");
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_reset();
        t_auto();
        t_pstate();
        t_demand();
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule
